// [bench/isd_drive_ctrl_tb_top.sv]
// Self-checking bench for the isolated switch drive control block
`timescale 1ns/1ps
module isd_drive_ctrl_tb_top
	import isd_pkg::*;
;
	// Short counts keep the run brief
	localparam int BURST = 8;
	localparam int SHOT = 5;
	localparam int PDT = 10;
	localparam logic [UA_W-1:0] EXP_UA [7] = '{13'h076C, 13'h0AF0,
		13'h0E74, 13'h1194, 13'h1450, 13'h1770, 13'h1A2C};

	logic			mclk = 1'b0;
	logic			sys_rst = 1'b1;
	logic			en_pin = 1'b0;
	logic			three_wire_mode = 1'b0;
	logic			one_shot_variant = 1'b0;
	logic [SET_W-1:0]	power_setting_pin = 4'h0;
	logic			prim_on = 1'b0;
	logic			hot = 1'b0;
	logic			cool = 1'b0;
	logic			sec_force = 1'b0;
	logic [1:0]		sec_force_lvl = 2'h0;
	isd_sense_t		sense;
	logic			gate_drive_out;
	logic			keep_off;
	logic			power_xfer;
	logic [CODE_W-1:0]	setting_code;
	logic [UA_W-1:0]	current_limit_ua;
	isd_status_t		status;
	int			bad_count = 0;
	int			check_count = 0;

	always #5 mclk = ~mclk;

	isd_drive_ctrl #(.BURST_ON_COUNT(BURST), .ONESHOT_COUNT(SHOT),
		.PD_TIMEOUT(PDT), .SEC_UV_FILTER(4)) u_isd_drive_ctrl (
		.mclk(mclk), .sys_rst(sys_rst), .en_pin(en_pin),
		.three_wire_mode(three_wire_mode),
		.one_shot_variant(one_shot_variant),
		.power_setting_pin(power_setting_pin), .sense(sense),
		.gate_drive_out(gate_drive_out), .keep_off(keep_off),
		.power_xfer(power_xfer), .setting_code(setting_code),
		.current_limit_ua(current_limit_ua), .status(status));

	isd_partner u_isd_partner (.mclk(mclk), .sys_rst(sys_rst),
		.en_pin(en_pin), .power_xfer(power_xfer), .prim_on(prim_on),
		.hot(hot), .cool(cool), .sec_force(sec_force),
		.sec_force_lvl(sec_force_lvl), .sense(sense));

	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task chk_bit(input logic got, input logic exp, input string msg);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask : chk_bit

	task chk_val(input logic [UA_W-1:0] got, input logic [UA_W-1:0] exp,
		input string msg);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask : chk_val

	function automatic logic pick(input int sel);
		case (sel)
			0: return gate_drive_out;
			1: return power_xfer;
			2: return keep_off;
			default: return status.secondary_undervoltage_lockout;
		endcase
	endfunction : pick

	// Samples land 1 ns after the edge so its updates have settled
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task set_en(input logic v);
		@(posedge mclk);
		en_pin <= v;
		#1;
	endtask : set_en

	task wait_for(input int sel, input logic val, input int lim);
		int n;
		n = 0;
		// Step off the edge so an output launched on it has settled
		#1;
		while (pick(sel) !== val && n < lim) begin
			tick(1);
			n++;
		end
		chk_bit(pick(sel), val, "wait");
	endtask : wait_for

	task count_high(input int sel, output int n);
		n = 0;
		while (pick(sel) === 1'b1 && n < 400) begin
			n++;
			tick(1);
		end
	endtask : count_high

	// Straps stay put from release onward, as capture needs
	task do_reset(input logic tw, input logic os, input logic [3:0] s);
		@(posedge mclk);
		sys_rst <= 1'b1;
		en_pin <= 1'b0;
		three_wire_mode <= tw;
		one_shot_variant <= os;
		power_setting_pin <= s;
		tick(11);
		chk_val({6'h0, gate_drive_out, keep_off, power_xfer, status},
			13'h002D, "reset");
		@(posedge mclk);
		sys_rst <= 1'b0;
		tick(6);
	endtask : do_reset

	task t_setting;
		int i;
		logic [CODE_W-1:0] c;
		for (i = 0; i < 16; i++) begin
			do_reset(1'b1, 1'b0, i[SET_W-1:0]);
			c = (i < 7) ? i[CODE_W-1:0] : 3'h0;
			chk_val({10'h0, setting_code}, {10'h0, c}, "code");
			chk_val(current_limit_ua, EXP_UA[c], "limit");
		end
		@(posedge mclk);
		power_setting_pin <= 4'h5;
		tick(6);
		chk_val({10'h0, setting_code}, 13'h0000, "late code");
		chk_val(current_limit_ua, 13'h076C, "late limit");
		$display("test setting done");
	endtask : t_setting

	task t_two_wire;
		int n;
		// One-shot strap must be ignored in two-wire, so the gate holds
		do_reset(1'b0, 1'b1, 4'h6);
		@(posedge mclk);
		en_pin <= 1'b1;
		prim_on <= 1'b1;
		wait_for(1, 1'b1, 20);
		count_high(1, n);
		chk_val(n[UA_W-1:0], UA_W'(BURST), "burst");
		wait_for(1, 1'b1, 20);
		count_high(1, n);
		chk_val(n[UA_W-1:0], UA_W'(BURST), "burst again");
		wait_for(0, 1'b1, 200);
		chk_bit(status.primary_undervoltage_lockout, 1'b0, "prim undervoltage_lockout");
		tick(20);
		chk_bit(gate_drive_out, 1'b1, "gate held");
		chk_bit(power_xfer, 1'b0, "full stops");
		set_en(1'b0);
		tick(3);
		chk_bit(gate_drive_out, 1'b0, "en low");
		chk_bit(power_xfer, 1'b0, "xfer off");
		$display("test two wire done");
	endtask : t_two_wire

	task ready3(input logic os);
		do_reset(1'b1, os, 4'h2);
		@(posedge mclk);
		prim_on <= 1'b1;
		wait_for(3, 1'b0, 200);
		chk_bit(gate_drive_out, 1'b0, "en low");
	endtask : ready3

	task t_three_std;
		repeat (2) begin
			set_en(1'b1);
			tick(2);
			chk_bit(gate_drive_out, 1'b0, "early");
			tick(1);
			chk_bit(gate_drive_out, 1'b1, "follow hi");
			set_en(1'b0);
			tick(3);
			chk_bit(gate_drive_out, 1'b0, "follow lo");
		end
		set_en(1'b1);
		tick(3);
		$display("test three wire done");
	endtask : t_three_std

	task t_droop;
		@(posedge mclk);
		sec_force <= 1'b1;
		sec_force_lvl <= 2'h0;
		@(posedge mclk);
		@(posedge mclk);
		sec_force_lvl <= 2'h3;
		@(posedge mclk);
		sec_force <= 1'b0;
		tick(8);
		chk_bit(gate_drive_out, 1'b1, "short droop");
		@(posedge mclk);
		sec_force <= 1'b1;
		sec_force_lvl <= 2'h0;
		tick(10);
		chk_bit(gate_drive_out, 1'b0, "long droop");
		chk_bit(keep_off, 1'b1, "keep off");
		@(posedge mclk);
		sec_force_lvl <= 2'h1;
		tick(10);
		chk_bit(status.secondary_undervoltage_lockout, 1'b1, "mid level");
		chk_bit(gate_drive_out, 1'b0, "mid gate");
		@(posedge mclk);
		sec_force_lvl <= 2'h2;
		wait_for(0, 1'b1, 8);
		@(posedge mclk);
		sec_force <= 1'b0;
		$display("test droop done");
	endtask : t_droop

	task t_thermal;
		@(posedge mclk);
		hot <= 1'b1;
		// Thermal flag is registered ahead of the gate: one edge more
		tick(4);
		chk_bit(power_xfer, 1'b0, "hot xfer");
		chk_bit(gate_drive_out, 1'b0, "hot gate");
		chk_bit(status.thermal_sd, 1'b1, "hot flag");
		@(posedge mclk);
		hot <= 1'b0;
		repeat (20) begin
			tick(1);
			chk_bit(power_xfer, 1'b0, "not cool");
		end
		@(posedge mclk);
		cool <= 1'b1;
		@(posedge mclk);
		cool <= 1'b0;
		wait_for(1, 1'b1, 10);
		wait_for(0, 1'b1, 10);
		$display("test thermal done");
	endtask : t_thermal

	task t_pd;
		@(posedge mclk);
		prim_on <= 1'b0;
		tick(4);
		chk_bit(gate_drive_out, 1'b0, "prim down");
		tick(PDT - 2);
		chk_bit(keep_off, 1'b0, "before timeout");
		wait_for(2, 1'b1, 8);
		chk_bit(gate_drive_out, 1'b0, "en ignored");
		$display("test power down done");
	endtask : t_pd

	task t_one_shot;
		int n;
		ready3(1'b1);
		repeat (2) begin
			set_en(1'b1);
			tick(3);
			count_high(0, n);
			chk_val(n[UA_W-1:0], UA_W'(SHOT), "pulse");
			tick(10);
			chk_bit(gate_drive_out, 1'b0, "spent");
			set_en(1'b0);
			tick(5);
		end
		$display("test one shot done");
	endtask : t_one_shot

	initial begin
		t_setting();
		t_two_wire();
		ready3(1'b0);
		t_three_std();
		t_droop();
		t_thermal();
		t_pd();
		t_one_shot();
		end_of_test();
	end

	// Whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		end_of_test();
	end
endmodule : isd_drive_ctrl_tb_top

// [bench/isd_partner.sv]
// Behavioural front end: primary cap, secondary rail and temperature
`timescale 1ns/1ps
module isd_partner
	import isd_pkg::*;
(
	input  wire logic	mclk,
	input  wire logic	sys_rst,
	input  wire logic	en_pin,
	input  wire logic	power_xfer,
	input  wire logic	prim_on,
	input  wire logic	hot,
	input  wire logic	cool,
	input  wire logic	sec_force,
	input  wire logic [1:0]	sec_force_lvl,
	output isd_sense_t	sense
);
	logic [2:0]	chg;
	logic [1:0]	lvl;
	logic		xfer_d;

	// Enable current charges the cap; each burst drains it
	always_ff @(posedge mclk) begin
		if (sys_rst || power_xfer)
			chg <= 3'h0;
		else if (en_pin && !chg[2])
			chg <= chg + 3'h1;
	end

	// Rail steps up per finished burst; level 1 sits between thresholds
	always_ff @(posedge mclk) begin
		xfer_d <= power_xfer;
		if (sys_rst)
			lvl <= 2'h0;
		else if (sec_force)
			lvl <= sec_force_lvl;
		else if (xfer_d && !power_xfer && lvl != 2'h3)
			lvl <= lvl + 2'h1;
	end

	assign sense = {chg[2], prim_on, !prim_on, lvl[1], lvl == 2'h0,
		lvl == 2'h3, hot, cool};
endmodule : isd_partner

// [design/isd_drive_ctrl.sv]
// Control logic of the isolated switch driver: transfer, lockout, gate
`timescale 1ns/1ps
module isd_drive_ctrl
	import isd_pkg::*;
#(
	parameter int BURST_ON_COUNT  = BURST_ON_CYC,
	parameter int ONESHOT_COUNT   = ONESHOT_CYC,
	parameter int PD_TIMEOUT      = PD_TIMEOUT_CYC,
	parameter int SEC_UV_FILTER   = SEC_UV_FILTER_CYC
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic              en_pin,
	input  wire logic              three_wire_mode,
	input  wire logic              one_shot_variant,
	input  wire logic [SET_W-1:0]  power_setting_pin,
	input  wire isd_sense_t        sense,
	output logic                   gate_drive_out,
	output logic                   keep_off,
	output logic                   power_xfer,
	output logic [CODE_W-1:0]      setting_code,
	output logic [UA_W-1:0]        current_limit_ua,
	output isd_status_t            status
);

	localparam logic [CNT_W-1:0] BURST_LAST   = CNT_W'(BURST_ON_COUNT - 1);
	localparam logic [CNT_W-1:0] ONESHOT_LAST = CNT_W'(ONESHOT_COUNT - 1);
	localparam logic [CNT_W-1:0] PD_LAST      = CNT_W'(PD_TIMEOUT - 1);
	localparam logic [CNT_W-1:0] FILTER_LAST  = CNT_W'(SEC_UV_FILTER - 1);

	// Counters are CNT_W wide, so larger counts cannot be served
	if (BURST_ON_COUNT < 1 || BURST_ON_COUNT >= (1 << CNT_W) ||
	    ONESHOT_COUNT < 1 || ONESHOT_COUNT >= (1 << CNT_W) ||
	    PD_TIMEOUT < 1 || PD_TIMEOUT >= (1 << CNT_W) ||
	    SEC_UV_FILTER < 1 || SEC_UV_FILTER >= (1 << CNT_W)) begin : g_bad
		$error("isd_drive_ctrl: timing count out of range");
	end

	isd_pins_t         pins_raw;
	isd_pins_t         pins_meta;
	isd_pins_t         pins;
	logic              en_d;
	logic              en_rise;
	logic [1:0]        settle_cnt;
	logic              sampled;
	logic              three_wire;
	logic              one_shot;
	logic              p_undervoltage_lockout;
	logic              s_undervoltage_lockout;
	logic [CNT_W-1:0]  sec_low_cnt;
	logic              thermal;
	logic [CNT_W-1:0]  burst_cnt;
	logic              burst_req;
	logic              burst_abort;
	logic [CNT_W-1:0]  pulse_cnt;
	logic [CNT_W-1:0]  pd_cnt;
	logic              pd_expired;
	logic              ready;
	logic              std_hold;
	logic              std_start;
	isd_gate_state_t   gd_state;
	isd_gate_state_t   next_gd_state;
	logic              next_keep_off;

	assign pins_raw = '{en: en_pin, three_wire: three_wire_mode,
		one_shot: one_shot_variant, setting: power_setting_pin,
		sense: sense};

	// Two-stage synchroniser for every asynchronous input
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pins_meta <= '0;
			pins      <= '0;
		end else begin
			pins_meta <= pins_raw;
			pins      <= pins_meta;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			en_d <= 1'b0;
		else
			en_d <= pins.en;
	end

	assign en_rise = pins.en & ~en_d;

	// Straps and setting are caught once after power-on; later edits ignored
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			settle_cnt       <= 2'h0;
			sampled          <= 1'b0;
			three_wire       <= 1'b0;
			one_shot         <= 1'b0;
			setting_code     <= SET_LOWEST;
			current_limit_ua <= LIMIT_UA[SET_LOWEST];
		end else if (!sampled) begin
			if (settle_cnt == SETTLE_LAST) begin
				sampled    <= 1'b1;
				three_wire <= pins.three_wire;
				one_shot   <= pins.one_shot & pins.three_wire;
				if (pins.setting < SET_NUM) begin
					setting_code     <= pins.setting[CODE_W-1:0];
					current_limit_ua <= LIMIT_UA[pins.setting[CODE_W-1:0]];
				end else begin
					setting_code     <= SET_LOWEST;
					current_limit_ua <= LIMIT_UA[SET_LOWEST];
				end
			end else begin
				settle_cnt <= settle_cnt + 2'h1;
			end
		end
	end

	// Primary lockout with hysteresis; entering wins over leaving
	always_ff @(posedge mclk) begin
		if (sys_rst)
			p_undervoltage_lockout <= 1'b1;
		else if (pins.sense.primary_below_uv_fall)
			p_undervoltage_lockout <= 1'b1;
		else if (pins.sense.primary_above_uv_rise)
			p_undervoltage_lockout <= 1'b0;
	end

	// Droop must persist past the filter, so gate switching dips pass
	always_ff @(posedge mclk) begin
		if (sys_rst)
			sec_low_cnt <= '0;
		else if (!pins.sense.sec_below_uv_fall)
			sec_low_cnt <= '0;
		else if (sec_low_cnt != FILTER_LAST)
			sec_low_cnt <= sec_low_cnt + CNT_W'(1);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			s_undervoltage_lockout <= 1'b1;
		else if (pins.sense.sec_below_uv_fall &&
		         sec_low_cnt == FILTER_LAST)
			s_undervoltage_lockout <= 1'b1;
		else if (pins.sense.sec_above_uv_rise)
			s_undervoltage_lockout <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			thermal <= 1'b0;
		else if (pins.sense.temp_hot)
			thermal <= 1'b1;
		else if (pins.sense.temp_cool)
			thermal <= 1'b0;
	end

	// Two-wire: a burst per charge threshold crossing keeps average input
	// current at the limit; three-wire: bursts run while primary is up
	assign burst_req = sampled && !thermal && (three_wire ?
		!p_undervoltage_lockout :
		(pins.en && pins.sense.primary_at_charge &&
		 !pins.sense.sec_full));
	assign burst_abort = thermal || (!three_wire && !pins.en);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			power_xfer <= 1'b0;
			burst_cnt  <= '0;
		end else if (!power_xfer) begin
			power_xfer <= burst_req;
			burst_cnt  <= '0;
		end else if (burst_abort || burst_cnt == BURST_LAST) begin
			power_xfer <= 1'b0;
			burst_cnt  <= '0;
		end else begin
			burst_cnt <= burst_cnt + CNT_W'(1);
		end
	end

	// Primary gone while secondary holds: keep-off after the timeout
	always_ff @(posedge mclk) begin
		if (sys_rst)
			pd_cnt <= '0;
		else if (!p_undervoltage_lockout || s_undervoltage_lockout)
			pd_cnt <= '0;
		else if (!pd_expired)
			pd_cnt <= pd_cnt + CNT_W'(1);
	end

	assign pd_expired = (pd_cnt == PD_LAST);

	assign ready = sampled && !p_undervoltage_lockout && !s_undervoltage_lockout && !thermal;
	assign std_hold  = pins.en && ready;
	assign std_start = std_hold && (three_wire || pins.sense.sec_full);

	always_comb begin
		next_gd_state = gd_state;
		case (gd_state)
			GD_OFF: begin
				if (one_shot) begin
					if (en_rise && ready)
						next_gd_state = GD_PULSE;
				end else if (std_start) begin
					next_gd_state = GD_ON;
				end
			end
			GD_ON: begin
				if (!std_hold)
					next_gd_state = GD_OFF;
			end
			GD_PULSE: begin
				if (!ready || pulse_cnt == ONESHOT_LAST)
					next_gd_state = GD_SPENT;
			end
			GD_SPENT: begin
				if (!pins.en)
					next_gd_state = GD_OFF;
			end
			default: next_gd_state = GD_OFF;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			gd_state <= GD_OFF;
		else
			gd_state <= next_gd_state;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || next_gd_state != GD_PULSE)
			pulse_cnt <= '0;
		else if (gd_state == GD_PULSE)
			pulse_cnt <= pulse_cnt + CNT_W'(1);
	end

	assign next_keep_off = !sampled || s_undervoltage_lockout || thermal ||
		(p_undervoltage_lockout && pd_expired);

	// Gate is high only in an active state and never under keep-off
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			gate_drive_out <= 1'b0;
			keep_off       <= 1'b1;
		end else begin
			keep_off       <= next_keep_off;
			gate_drive_out <= (next_gd_state == GD_ON ||
				next_gd_state == GD_PULSE) && ready &&
				!next_keep_off;
		end
	end

	assign status = '{primary_undervoltage_lockout: p_undervoltage_lockout, secondary_undervoltage_lockout: s_undervoltage_lockout,
		thermal_sd: thermal, keep_off: keep_off};

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	property p_no_xfer_en_low;
		(sampled && !three_wire && !pins.en) |=> !$rose(power_xfer);
	endproperty
	a_no_xfer_en_low: assert property (p_no_xfer_en_low)
		else $error("two-wire burst started with enable low");

	property p_burst_len;
		(power_xfer && burst_cnt == BURST_LAST) |=> !power_xfer;
	endproperty
	a_burst_len: assert property (p_burst_len)
		else $error("burst ran past its fixed on-time");

	property p_burst_early_end;
		$fell(power_xfer) |-> ($past(burst_cnt) == BURST_LAST ||
			$past(thermal) || (!three_wire && !$past(pins.en)));
	endproperty
	a_burst_early_end: assert property (p_burst_early_end)
		else $error("burst ended early without cause");

	property p_two_wire_on;
		(gd_state == GD_OFF && !one_shot && !three_wire && pins.en &&
		 ready && pins.sense.sec_full) |=> gate_drive_out;
	endproperty
	a_two_wire_on: assert property (p_two_wire_on)
		else $error("two-wire gate did not rise with rail full");

	property p_en_fall_off;
		(!three_wire && $fell(pins.en)) |=> (!gate_drive_out && !power_xfer);
	endproperty
	a_en_fall_off: assert property (p_en_fall_off)
		else $error("two-wire enable fall left gate or transfer on");

	property p_setting_range;
		sampled |-> (setting_code < CODE_W'(SET_NUM) &&
			current_limit_ua == LIMIT_UA[setting_code]);
	endproperty
	a_setting_range: assert property (p_setting_range)
		else $error("current limit does not match the setting");

	property p_setting_held;
		(sampled && $past(sampled)) |-> $stable(setting_code);
	endproperty
	a_setting_held: assert property (p_setting_held)
		else $error("power setting changed after power-up");

	property p_undervoltage_lockout_low;
		(p_undervoltage_lockout || s_undervoltage_lockout) |=> !gate_drive_out;
	endproperty
	a_undervoltage_lockout_low: assert property (p_undervoltage_lockout_low)
		else $error("gate high during lockout");

	property p_gate_needs_rails;
		gate_drive_out |-> $past(!p_undervoltage_lockout && !s_undervoltage_lockout);
	endproperty
	a_gate_needs_rails: assert property (p_gate_needs_rails)
		else $error("gate high without both rails up");

	property p_hysteresis;
		(p_undervoltage_lockout && !pins.sense.primary_above_uv_rise) |=> p_undervoltage_lockout;
	endproperty
	a_hysteresis: assert property (p_hysteresis)
		else $error("primary lockout left below the rising threshold");

	property p_droop_ignored;
		(!s_undervoltage_lockout && sec_low_cnt != FILTER_LAST) |=> !s_undervoltage_lockout;
	endproperty
	a_droop_ignored: assert property (p_droop_ignored)
		else $error("secondary lockout on a short droop");

	property p_thermal_stop;
		thermal |=> !power_xfer;
	endproperty
	a_thermal_stop: assert property (p_thermal_stop)
		else $error("transfer running in thermal shutdown");

	property p_thermal_gate;
		(thermal && !p_undervoltage_lockout) |=> !gate_drive_out;
	endproperty
	a_thermal_gate: assert property (p_thermal_gate)
		else $error("gate high in thermal shutdown");

	property p_thermal_hold;
		(thermal && !pins.sense.temp_cool) |=> thermal;
	endproperty
	a_thermal_hold: assert property (p_thermal_hold)
		else $error("thermal shutdown left before cooling");

	property p_follow;
		(ready && three_wire && !one_shot && gd_state != GD_OFF &&
		 !next_keep_off) |=> (gate_drive_out == $past(pins.en));
	endproperty
	a_follow: assert property (p_follow)
		else $error("standard enable gate does not follow enable");

	property p_one_shot_once;
		(gd_state == GD_SPENT && pins.en) |=> !gate_drive_out;
	endproperty
	a_one_shot_once: assert property (p_one_shot_once)
		else $error("second pulse without enable returning low");

	property p_timeout;
		(p_undervoltage_lockout && pd_expired) |=> keep_off;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("driver not disabled after primary timeout");

	property p_keep_off;
		keep_off |-> !gate_drive_out;
	endproperty
	a_keep_off: assert property (p_keep_off)
		else $error("gate high with keep-off applied");

	c_burst_done: cover property (power_xfer && burst_cnt == BURST_LAST);
	c_two_wire_on: cover property (!three_wire && $rose(gate_drive_out));
	c_one_shot: cover property (one_shot && $fell(gate_drive_out));
	c_thermal: cover property ($rose(thermal));
	c_timeout: cover property (p_undervoltage_lockout && $rose(keep_off));

endmodule : isd_drive_ctrl

// [design/isd_pkg.sv]
// Shared constants and types for the isolated switch drive control block
package isd_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int BURST_ON_NS       = 3300;
	localparam int BURST_ON_CYC      =
		(BURST_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ONESHOT_NS        = 2000;
	localparam int ONESHOT_CYC       = ONESHOT_NS / CLK_PERIOD_NS;
	localparam int PD_TIMEOUT_NS     = 10000;
	localparam int PD_TIMEOUT_CYC    = PD_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int SEC_UV_FILTER_NS  = 500;
	localparam int SEC_UV_FILTER_CYC = SEC_UV_FILTER_NS / CLK_PERIOD_NS;

	// Counter and code widths
	localparam int CNT_W  = 16;
	localparam int SET_W  = 4;
	localparam int CODE_W = 3;
	localparam int UA_W   = 13;

	// Power setting codes
	localparam logic [SET_W-1:0]  SET_NUM    = 4'h7;
	localparam logic [CODE_W-1:0] SET_LOWEST = 3'h0;

	// Settle cycles before the power-up sample, covers the synchroniser
	localparam logic [1:0] SETTLE_LAST = 2'h2;

	// Enable input current limit per setting, in microamps
	localparam logic [UA_W-1:0] LIMIT_UA [7] = '{
		13'h076C, 13'h0AF0, 13'h0E74, 13'h1194,
		13'h1450, 13'h1770, 13'h1A2C
	};

	// Threshold comparator results from the analog front end
	typedef struct packed {
		logic primary_at_charge;
		logic primary_above_uv_rise;
		logic primary_below_uv_fall;
		logic sec_above_uv_rise;
		logic sec_below_uv_fall;
		logic sec_full;
		logic temp_hot;
		logic temp_cool;
	} isd_sense_t;

	// Everything that arrives from outside the clock domain
	typedef struct packed {
		logic             en;
		logic             three_wire;
		logic             one_shot;
		logic [SET_W-1:0] setting;
		isd_sense_t       sense;
	} isd_pins_t;

	typedef struct packed {
		logic primary_undervoltage_lockout;
		logic secondary_undervoltage_lockout;
		logic thermal_sd;
		logic keep_off;
	} isd_status_t;

	typedef enum {
		GD_OFF,
		GD_ON,
		GD_PULSE,
		GD_SPENT
	} isd_gate_state_t;

endpackage : isd_pkg
